/* File: logic/flseq_pkg.sv */
package flseq_pkg;
   localparam int ARR_AW = 12;
   localparam int ROW_AW = 5;
   localparam int ROW_W = ARR_AW - ROW_AW;
   localparam logic [15:0] ARR_BASE = 16'hF000;
   localparam logic [15:0] ARR_MASK = 16'hF000;
   localparam logic [ARR_AW-1:0] ARR_LAST = 12'hFFF;
   localparam logic [7:0] BP_UNPROT = 8'hFF;
   localparam logic [7:0] ERASED = 8'hFF;
   // Trim bytes, erased like any other location
   localparam logic [15:0] TRIM_LO_ADDR = 16'hFFC0;
   localparam logic [15:0] TRIM_HI_ADDR = 16'hFFC1;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 10;
   localparam int NV_SETUP_NS = 10000;
   localparam int WHOLE_ERASE_NS = 4000000;
   localparam int HV_HOLD_NS = 100000;
   localparam int PROG_SETUP_NS = 5000;
   localparam int READ_RCV_NS = 1000;
   localparam int RCV_W = 8;
   localparam logic [RCV_W-1:0] RCV_CYC = RCV_W'((READ_RCV_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [RCV_W-1:0] RCV_ONE = 8'h01;

   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_SEL = 7'h02,
      S_WAITW = 7'h04,
      S_ARMED = 7'h08,
      S_HV = 7'h10,
      S_HOLD = 7'h20,
      S_RECOV = 7'h40
   } flseq_state_e;

   typedef struct packed {
      flseq_state_e st;
      logic erase_mode;
      logic erase_ok;
      logic blocked;
      logic erase_done;
      logic [ROW_W-1:0] row;
      logic [ARR_AW-1:0] sweep;
      logic [RCV_W-1:0] rcv;
      logic rvalid;
      logic rerr;
      logic prog_cfg;
      logic hv_on;
      logic read_ready;
   } flseq_st_s;

   function automatic logic in_array(input logic [15:0] a);
      in_array = (a & ARR_MASK) == ARR_BASE;
   endfunction : in_array

   function automatic logic reads_allowed(input flseq_state_e s);
      reads_allowed = (s == S_IDLE) || (s == S_SEL) || (s == S_WAITW) || (s == S_ARMED);
   endfunction : reads_allowed
endpackage : flseq_pkg

/* File: logic/flseq_arr_if.sv */
`timescale 1ns/1ns
interface flseq_arr_if;
   import flseq_pkg::*;
   logic [ARR_AW-1:0] addr;
   logic [7:0] wdata;
   logic we;
   logic re;
   logic [7:0] rdata;
   modport ctrl (output addr, output wdata, output we, output re, input rdata);
   modport mem (input addr, input wdata, input we, input re, output rdata);
endinterface : flseq_arr_if

/* File: logic/flseq_array.sv */
`timescale 1ns/1ns
module flseq_array
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // Array port
   flseq_arr_if.mem arr
);
   import flseq_pkg::*;

   typedef struct packed {
      logic [7:0] rdata;
   } flseq_arr_s;

   logic [7:0] cells [0:(1 << ARR_AW) - 1];
   flseq_arr_s q;
   flseq_arr_s next_q;

   always_comb
   begin
      next_q = q;
      if (arr.re)
      begin
         next_q.rdata = cells[arr.addr];
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end

   // Cell contents survive reset
   always_ff @(posedge sys_clk_i)
   begin
      if (arr.we)
      begin
         cells[arr.addr] <= arr.wdata;
      end
   end

   assign arr.rdata = q.rdata;
endmodule : flseq_array

/* File: logic/flseq_top.sv */
`timescale 1ns/1ns
module flseq_top
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // Control bits from software
   input wire logic erase_sel_i,
   input wire logic mass_sel_i,
   input wire logic program_select_i,
   input wire logic high_voltage_enable_i,
   // Block protect and monitor
   input wire logic [7:0] block_protect_reg_i,
   input wire logic bp_read_i,
   input wire logic bp_write_i,
   input wire logic monitor_fail_i,
   // CPU bus
   input wire logic [15:0] bus_addr_i,
   input wire logic [7:0] bus_wdata_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   output logic [7:0] bus_rdata_o,
   output logic bus_rvalid_o,
   output logic bus_rerr_o,
   // Status
   output logic prog_cfg_o,
   output logic hv_active_o,
   output logic read_ready_o,
   output logic erase_blocked_o,
   output logic erase_done_o
);
   import flseq_pkg::*;

   localparam int RCV_N = int'(RCV_CYC);

   flseq_arr_if arr ();
   flseq_st_s q;
   flseq_st_s next_q;
   logic held;
   logic arm;
   logic rd_hit;

   flseq_array u_array
   (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .arr(arr)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      held = q.erase_mode ? (erase_sel_i && mass_sel_i) : program_select_i;
      // In erase mode only, monitor-fail lets a block-protect write stand in for the array write
      arm = (bus_wr_i && in_array(bus_addr_i))
            || (monitor_fail_i && bp_write_i && q.erase_mode);
      rd_hit = bus_rd_i && in_array(bus_addr_i);
      next_q = q;
      next_q.rvalid = 1'b0;
      next_q.rerr = 1'b0;
      arr.addr = bus_addr_i[ARR_AW-1:0];
      arr.wdata = bus_wdata_i;
      arr.we = 1'b0;
      arr.re = 1'b0;
      if (rd_hit)
      begin
         next_q.rvalid = 1'b1;
         if (reads_allowed(q.st))
         begin
            arr.re = 1'b1;
         end
         else
         begin
            next_q.rerr = 1'b1;
         end
      end
      case (q.st)
         S_IDLE:
         begin
            next_q.erase_done = 1'b0;
            next_q.blocked = 1'b0;
            next_q.erase_ok = 1'b0;
            if (erase_sel_i && mass_sel_i)
            begin
               next_q.erase_mode = 1'b1;
               next_q.st = S_SEL;
            end
            else if (program_select_i)
            begin
               next_q.erase_mode = 1'b0;
               next_q.st = S_SEL;
            end
         end
         S_SEL:
         begin
            // Other bus traffic leaves the step pending
            if (!held)
            begin
               next_q.st = S_IDLE;
            end
            else if (bp_read_i)
            begin
               next_q.st = S_WAITW;
            end
         end
         S_WAITW:
         begin
            if (!held)
            begin
               next_q.st = S_IDLE;
            end
            else if (arm)
            begin
               next_q.row = bus_addr_i[ARR_AW-1:ROW_AW];
               next_q.erase_ok = block_protect_reg_i == BP_UNPROT;
               next_q.blocked = q.erase_mode && (block_protect_reg_i != BP_UNPROT);
               next_q.st = S_ARMED;
            end
         end
         S_ARMED:
         begin
            if (!held)
            begin
               next_q.st = S_IDLE;
            end
            else if (high_voltage_enable_i)
            begin
               next_q.sweep = '0;
               next_q.st = S_HV;
            end
         end
         S_HV:
         begin
            if (!high_voltage_enable_i)
            begin
               next_q.rcv = '0;
               next_q.st = S_RECOV;
            end
            else if (!held)
            begin
               next_q.st = S_HOLD;
            end
            else if (q.erase_mode)
            begin
               if (q.erase_ok && !q.erase_done)
               begin
                  // One byte per cycle, trim bytes included
                  arr.we = 1'b1;
                  arr.addr = q.sweep;
                  arr.wdata = ERASED;
                  next_q.sweep = q.sweep + 1'b1;
                  if (q.sweep == ARR_LAST)
                  begin
                     next_q.erase_done = 1'b1;
                  end
               end
            end
            else if (bus_wr_i && in_array(bus_addr_i)
                     && (bus_addr_i[ARR_AW-1:ROW_AW] == q.row))
            begin
               arr.we = 1'b1;
            end
         end
         S_HOLD:
         begin
            if (!high_voltage_enable_i)
            begin
               next_q.rcv = '0;
               next_q.st = S_RECOV;
            end
         end
         S_RECOV:
         begin
            next_q.rcv = q.rcv + RCV_ONE;
            if (q.rcv == RCV_CYC - RCV_ONE)
            begin
               next_q.st = S_IDLE;
            end
         end
         default:
         begin
            next_q.st = S_IDLE;
         end
      endcase
      next_q.prog_cfg = !next_q.erase_mode && (next_q.st != S_IDLE)
                        && (next_q.st != S_RECOV);
      next_q.hv_on = (next_q.st == S_HV) || (next_q.st == S_HOLD);
      next_q.read_ready = reads_allowed(next_q.st);
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         q <= '{st: S_IDLE, read_ready: 1'b1, default: '0};
      end
      else
      begin
         q <= next_q;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign bus_rdata_o = arr.rdata;
   assign bus_rvalid_o = q.rvalid;
   assign bus_rerr_o = q.rerr;
   assign prog_cfg_o = q.prog_cfg;
   assign hv_active_o = q.hv_on;
   assign read_ready_o = q.read_ready;
   assign erase_blocked_o = q.blocked;
   assign erase_done_o = q.erase_done;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);

   a_blocked_no_erase: assert property ((q.blocked && q.erase_mode) |-> !arr.we)
      else $error("protected array was erased");
   a_erase_writes_ones: assert property ((arr.we && q.erase_mode) |-> arr.wdata == ERASED)
      else $error("erase wrote a value other than all ones");
   a_prog_in_row: assert property ((arr.we && !q.erase_mode) |->
      (arr.addr[ARR_AW-1:ROW_AW] == q.row))
      else $error("program write outside latched row");
   a_prog_config: assert property ((q.st == S_HV && !q.erase_mode) |-> q.prog_cfg)
      else $error("program configuration missing during high voltage");
   a_recov_stays: assert property ((q.st == S_RECOV && q.rcv < RCV_CYC - RCV_ONE) |=>
      (q.st == S_RECOV && !q.read_ready))
      else $error("recovery left early");
   a_recov_length: assert property ($rose(q.st == S_RECOV) |->
      ##[RCV_N:RCV_N] (q.st == S_IDLE && q.read_ready))
      else $error("recovery length wrong");
   a_read_refused: assert property ((rd_hit && !reads_allowed(q.st)) |=>
      (bus_rvalid_o && bus_rerr_o))
      else $error("array read not refused while busy");
   a_unrelated_ignored: assert property ((q.st == S_WAITW && held && !arm) |=>
      q.st == S_WAITW)
      else $error("sequence disturbed by unrelated traffic");
   a_monitor_arm: assert property ((q.st == S_WAITW && held && q.erase_mode
      && monitor_fail_i && bp_write_i) |=> q.st == S_ARMED)
      else $error("block protect write did not arm erase");
   a_erase_sweep_done: assert property ((q.st == S_HV && q.erase_mode && q.erase_ok
      && high_voltage_enable_i && held && q.sweep == ARR_LAST) |=> q.erase_done)
      else $error("erase sweep did not finish");
endmodule : flseq_top

/* File: testbench/flseq_cpu_model.sv */
`timescale 1ns/1ns
module flseq_cpu_model
(
   // Clock
   input wire logic sys_clk_i,
   // Control bits
   output logic erase_sel_o,
   output logic mass_sel_o,
   output logic program_select_o,
   output logic high_voltage_enable_o,
   // Block protect strobes
   output logic bp_read_o,
   output logic bp_write_o,
   // CPU bus
   output logic [15:0] bus_addr_o,
   output logic [7:0] bus_wdata_o,
   output logic bus_wr_o,
   output logic bus_rd_o
);
   import flseq_pkg::*;
   initial
   begin
      {erase_sel_o, mass_sel_o, program_select_o, high_voltage_enable_o} = 4'h0;
      {bp_read_o, bp_write_o, bus_wr_o, bus_rd_o} = 4'h0;
      bus_addr_o = 16'h0000;
      bus_wdata_o = 8'h00;
   end
   // Released bus shows inverted values
   task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      bus_wr_o <= wr;
      bus_rd_o <= !wr;
      bus_addr_o <= a;
      bus_wdata_o <= d;
      @(posedge sys_clk_i);
      bus_wr_o <= 1'b0;
      bus_rd_o <= 1'b0;
      bus_addr_o <= ~a;
      bus_wdata_o <= ~d;
   endtask : access
   task automatic start(input logic prog, input logic mon, input logic [15:0] a,
      input logic [7:0] d);
      @(posedge sys_clk_i);
      erase_sel_o <= !prog;
      mass_sel_o <= !prog;
      program_select_o <= prog;
      @(posedge sys_clk_i);
      bp_read_o <= 1'b1;
      @(posedge sys_clk_i);
      bp_read_o <= 1'b0;
      access(1'b0, 16'h0080, 8'h00);
      if (mon)
      begin
         @(posedge sys_clk_i);
         bp_write_o <= 1'b1;
         @(posedge sys_clk_i);
         bp_write_o <= 1'b0;
      end
      else
         access(1'b1, a, d);
      repeat (NV_SETUP_NS / CLK_NS) @(posedge sys_clk_i);
      high_voltage_enable_o <= 1'b1;
      if (prog)
         repeat (PROG_SETUP_NS / CLK_NS) @(posedge sys_clk_i);
   endtask : start
   task automatic finish;
      @(posedge sys_clk_i);
      erase_sel_o <= 1'b0;
      mass_sel_o <= 1'b0;
      program_select_o <= 1'b0;
      repeat (HV_HOLD_NS / CLK_NS) @(posedge sys_clk_i);
      high_voltage_enable_o <= 1'b0;
   endtask : finish
endmodule : flseq_cpu_model

/* File: testbench/flash_erase_program_sequencer_test.sv */
`timescale 1ns/1ns
module flash_erase_program_sequencer_test;
   import flseq_pkg::*;
   logic sys_clk_i, srst_i, erase_sel, mass_sel, program_select, hv, bp_rd, bp_wr, wr, rd_s, mon;
   logic [15:0] addr;
   logic [7:0] wdata, bp_reg, rdata;
   logic rvalid, rerr, prog_cfg, hv_act, rdy, blocked, done;
   logic [8:0] exp_q [$];
   logic [8:0] e;
   logic [15:0] rnd, ra;
   logic [7:0] row [32];
   logic [15:0] probe [4] = '{TRIM_LO_ADDR, TRIM_HI_ADDR, ARR_BASE, 16'hFFFF};
   int err_count = 0;
   int comparisons = 0;
   flseq_cpu_model i_cpu (.sys_clk_i(sys_clk_i), .erase_sel_o(erase_sel),
      .mass_sel_o(mass_sel), .program_select_o(program_select), .high_voltage_enable_o(hv),
      .bp_read_o(bp_rd), .bp_write_o(bp_wr), .bus_addr_o(addr), .bus_wdata_o(wdata),
      .bus_wr_o(wr), .bus_rd_o(rd_s));
   flseq_top i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .erase_sel_i(erase_sel),
      .mass_sel_i(mass_sel), .program_select_i(program_select), .high_voltage_enable_i(hv),
      .block_protect_reg_i(bp_reg), .bp_read_i(bp_rd), .bp_write_i(bp_wr),
      .monitor_fail_i(mon), .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_wr_i(wr),
      .bus_rd_i(rd_s), .bus_rdata_o(rdata), .bus_rvalid_o(rvalid), .bus_rerr_o(rerr),
      .prog_cfg_o(prog_cfg), .hv_active_o(hv_act), .read_ready_o(rdy),
      .erase_blocked_o(blocked), .erase_done_o(done));
   // ---------
   // Helpers
   // ---------
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic rd(input logic [15:0] a, input logic [8:0] x);
      exp_q.push_back(x);
      i_cpu.access(1'b0, a, 8'h00);
   endtask : rd
   // Refused read inside recovery, then its length
   task automatic recover;
      int n;
      n = 0;
      while (rdy !== 1'b0 && n < 10)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      rd(16'hF800, 9'h100);
      n = 2;
      while (rdy !== 1'b1 && n < 300)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      // Counted from the drop edge: entry edge and ready register add two
      check("recovery span", 9'(n), 9'(RCV_CYC) + 9'h002);
   endtask : recover
   // ---------
   // Clock, watchdog, read checker
   // ---------
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   initial
   begin
      repeat (60000) @(posedge sys_clk_i);
      err_count++;
      tally_and_finish();
   end
   always @(posedge sys_clk_i)
   begin
      if (rvalid === 1'b1)
      begin
         check("read expected", {8'h00, 1'(exp_q.size() > 0)}, 9'h001);
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h0FF;
         check("read refused", {8'h00, rerr}, {8'h00, e[8]});
         if (e[8] === 1'b0)
            check("read data", {1'b0, rdata}, e);
      end
   end
   // ---------
   // Scenarios
   // ---------
   initial
   begin
      srst_i = 1'b1;
      bp_reg = 8'h7F;
      mon = 1'b0;
      rnd = 16'h0009;
      repeat (20) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      @(posedge sys_clk_i);
      check("ready after reset", {8'h00, rdy}, 9'h001);
      // Protected whole erase
      rnd = lfsr(rnd);
      i_cpu.start(1'b0, 1'b0, {4'hF, rnd[11:0]}, rnd[7:0]);
      repeat (3) @(posedge sys_clk_i);
      check("erase blocked", {8'h00, blocked}, 9'h001);
      i_cpu.finish();
      recover();
      check("blocked erase done", {8'h00, done}, 9'h000);
      // Monitor-armed erase; erase time cut to the sweep
      bp_reg <= BP_UNPROT;
      mon <= 1'b1;
      i_cpu.start(1'b0, 1'b1, 16'h0000, 8'h00);
      repeat (3) @(posedge sys_clk_i);
      check("hv active", {8'h00, hv_act}, 9'h001);
      rd(TRIM_LO_ADDR, 9'h100);
      wait_done : for (int n = 0; n < 5000; n++)
      begin
         if (done === 1'b1)
            break;
         @(posedge sys_clk_i);
      end
      check("erase done", {8'h00, done}, 9'h001);
      i_cpu.finish();
      recover();
      mon <= 1'b0;
      foreach (probe[k])
         rd(probe[k], {1'b0, ERASED});
      // Row program on erased bytes, plus one write past the row
      rnd = lfsr(rnd);
      ra = {4'hF, 1'b0, rnd[10:5], 5'h00};
      i_cpu.start(1'b1, 1'b0, ra + 16'h0011, rnd[7:0]);
      check("program config", {8'h00, prog_cfg}, 9'h001);
      for (int n = 0; n < 32; n++)
      begin
         rnd = lfsr(rnd);
         row[n] = rnd[7:0];
         i_cpu.access(1'b1, ra + 16'(n), row[n]);
      end
      i_cpu.access(1'b1, ra + 16'h0020, 8'h00);
      i_cpu.finish();
      recover();
      for (int n = 0; n < 32; n++)
         rd(ra + 16'(n), {1'b0, row[n]});
      rd(ra + 16'h0020, {1'b0, ERASED});
      repeat (4) @(posedge sys_clk_i);
      check("reads answered", 9'(exp_q.size()), 9'h000);
      tally_and_finish();
   end
endmodule : flash_erase_program_sequencer_test
